// file: verilog/crf_core_regs.v
// Core register set, condition flags, stack pointer and arithmetic datapath.
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.vh"
// Overview of operation
// - Six internal registers, reached only through operations.
// - Eight-bit accumulator feeds and receives arithmetic.
// - Two index registers; second one selected by prefix.
// - Interrupt context save leaves second index untouched.
// - Sixteen-bit program counter from low and high bytes.
// - Eight-bit flags, reset 111x1xxx, pushable and poppable.
// - Half carry from bit three on add.
// - Negative flag copies result bit seven.
// - Zero flag set when result is zero.
// - Carry flags overflow; set and reset operations.
// - Carry also from bit test, shift, rotate.
// - Two mask bits encode four priority levels.
// - Interrupt entry loads mask bits from priority.
// - Mask bits changed by listed control operations.
// - Each flag individually testable for branches.
// - Unsigned eight by eight multiply.
// - Stack pointer decrements after push, increments before pop.
// - Stack pointer resets to 017F, upper bits fixed.
// - Call uses two bytes, interrupt five, low first.
module crf_core_regs
(
  // Clock and reset.
  input wire clk_sys_in,
  input wire rst_n_in,
  // Operation request.
  input wire [4:0] op_in,
  input wire [1:0] dst_sel_in,
  input wire prefix_in,
  input wire [7:0] operand_in,
  input wire [7:0] wr_flags_in,
  input wire [15:0] pc_load_in,
  input wire [1:0] irq_priority_in,
  input wire [2:0] bit_sel_in,
  input wire [2:0] br_cond_in,
  input wire br_true_in,
  // Register state.
  output reg [7:0] acc_out,
  output reg [7:0] idx1_out,
  output reg [7:0] idx2_out,
  output reg [7:0] program_counter_low_out,
  output reg [7:0] program_counter_high_out,
  output reg [7:0] condition_flags_out,
  output reg [15:0] stack_pointer_out,
  output reg branch_taken_out
);

  reg [7:0] acc_q;
  reg [7:0] idx1_q;
  reg [7:0] idx2_q;
  reg [15:0] program_counter_q;
  reg [7:0] condition_flags_q;
  reg [15:0] stack_pointer_q;
  reg [7:0] acc_d;
  reg [7:0] idx1_d;
  reg [7:0] idx2_d;
  reg [15:0] program_counter_d;
  reg [7:0] condition_flags_d;
  reg [15:0] stack_pointer_d;
  reg [7:0] index_sel;
  reg [7:0] result;
  reg [8:0] sum9;
  reg [4:0] sum5;
  reg [15:0] product;
  reg upd_nz;
  reg write_res;
  reg cond_bit;

  // ---------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------
  always @*
  begin
    acc_d = acc_q;
    idx1_d = idx1_q;
    idx2_d = idx2_q;
    program_counter_d = program_counter_q;
    condition_flags_d = condition_flags_q;
    stack_pointer_d = stack_pointer_q;
    index_sel = prefix_in ? idx2_q : idx1_q;
    result = 8'h00;
    sum9 = 9'h000;
    sum5 = 5'h00;
    product = 16'h0000;
    upd_nz = 1'b0;
    write_res = 1'b0;
    cond_bit = 1'b0;
    case (op_in)
      `CRF_OP_ADD, `CRF_OP_ADC:
      begin
        // Carry in is used only by the add-with-carry form.
        sum9 = {1'b0, acc_q} + {1'b0, operand_in}
          + {8'h00, (op_in == `CRF_OP_ADC) & condition_flags_q[`CRF_BIT_C]};
        sum5 = {1'b0, acc_q[3:0]} + {1'b0, operand_in[3:0]}
          + {4'h0, (op_in == `CRF_OP_ADC) & condition_flags_q[`CRF_BIT_C]};
        result = sum9[7:0];
        condition_flags_d[`CRF_BIT_H] = sum5[4];
        condition_flags_d[`CRF_BIT_C] = sum9[8];
        upd_nz = 1'b1;
        write_res = 1'b1;
      end
      `CRF_OP_SUB, `CRF_OP_SBC:
      begin
        sum9 = {1'b0, acc_q} - {1'b0, operand_in}
          - {8'h00, (op_in == `CRF_OP_SBC) & condition_flags_q[`CRF_BIT_C]};
        result = sum9[7:0];
        condition_flags_d[`CRF_BIT_C] = sum9[8];
        upd_nz = 1'b1;
        write_res = 1'b1;
      end
      `CRF_OP_AND:
      begin
        result = acc_q & operand_in;
        upd_nz = 1'b1;
        write_res = 1'b1;
      end
      `CRF_OP_OR:
      begin
        result = acc_q | operand_in;
        upd_nz = 1'b1;
        write_res = 1'b1;
      end
      `CRF_OP_XOR:
      begin
        result = acc_q ^ operand_in;
        upd_nz = 1'b1;
        write_res = 1'b1;
      end
      `CRF_OP_LD:
      begin
        result = operand_in;
        upd_nz = 1'b1;
        write_res = 1'b1;
      end
      `CRF_OP_SHL, `CRF_OP_RLC:
      begin
        result = {operand_in[6:0],
          (op_in == `CRF_OP_RLC) & condition_flags_q[`CRF_BIT_C]};
        condition_flags_d[`CRF_BIT_C] = operand_in[7];
        upd_nz = 1'b1;
        write_res = 1'b1;
      end
      `CRF_OP_SHR, `CRF_OP_RRC:
      begin
        result = {(op_in == `CRF_OP_RRC) & condition_flags_q[`CRF_BIT_C],
          operand_in[7:1]};
        condition_flags_d[`CRF_BIT_C] = operand_in[0];
        upd_nz = 1'b1;
        write_res = 1'b1;
      end
      `CRF_OP_MUL:
      begin
        // Product high byte goes to the index register, low byte to the accumulator.
        product = index_sel * acc_q;
        acc_d = product[7:0];
        if (prefix_in)
        begin
          idx2_d = product[15:8];
        end
        else
        begin
          idx1_d = product[15:8];
        end
        condition_flags_d[`CRF_BIT_H] = 1'b0;
        condition_flags_d[`CRF_BIT_C] = 1'b0;
      end
      `CRF_OP_BTJ:
      begin
        condition_flags_d[`CRF_BIT_C] = operand_in[bit_sel_in];
      end
      `CRF_OP_SCF:
      begin
        condition_flags_d[`CRF_BIT_C] = 1'b1;
      end
      `CRF_OP_RCF:
      begin
        condition_flags_d[`CRF_BIT_C] = 1'b0;
      end
      `CRF_OP_RIM:
      begin
        {condition_flags_d[`CRF_BIT_I1], condition_flags_d[`CRF_BIT_I0]}
          = `CRF_LVL_MAIN;
      end
      `CRF_OP_SIM, `CRF_OP_HALT, `CRF_OP_WFI:
      begin
        // Halt and wait reopen interrupts; disable masks them all.
        {condition_flags_d[`CRF_BIT_I1], condition_flags_d[`CRF_BIT_I0]}
          = (op_in == `CRF_OP_SIM) ? `CRF_LVL_DISABLE : `CRF_LVL_MAIN;
      end
      `CRF_OP_WRFLAGS, `CRF_OP_POPF, `CRF_OP_IRQ_RETURN_OP:
      begin
        condition_flags_d = wr_flags_in | `CRF_FIXED_ONES;
        if (op_in != `CRF_OP_WRFLAGS)
        begin
          stack_pointer_d = `CRF_SP_FIXED | (`CRF_SP_LOW_MASK
            & (stack_pointer_q + ((op_in == `CRF_OP_IRQ_RETURN_OP) ? {13'h0000, `CRF_IRQ_BYTES}
            : 16'h0001)));
        end
        if (op_in == `CRF_OP_IRQ_RETURN_OP)
        begin
          program_counter_d = pc_load_in;
        end
      end
      `CRF_OP_PUSHF:
      begin
        stack_pointer_d = `CRF_SP_FIXED | (`CRF_SP_LOW_MASK & (stack_pointer_q - 16'h0001));
      end
      `CRF_OP_CALL:
      begin
        stack_pointer_d = `CRF_SP_FIXED
          | (`CRF_SP_LOW_MASK & (stack_pointer_q - {13'h0000, `CRF_CALL_BYTES}));
        program_counter_d = pc_load_in;
      end
      `CRF_OP_RET:
      begin
        stack_pointer_d = `CRF_SP_FIXED
          | (`CRF_SP_LOW_MASK & (stack_pointer_q + {13'h0000, `CRF_CALL_BYTES}));
        program_counter_d = pc_load_in;
      end
      `CRF_OP_IRQ:
      begin
        // Context of program counter, index one, accumulator and flags only.
        stack_pointer_d = `CRF_SP_FIXED
          | (`CRF_SP_LOW_MASK & (stack_pointer_q - {13'h0000, `CRF_IRQ_BYTES}));
        {condition_flags_d[`CRF_BIT_I1], condition_flags_d[`CRF_BIT_I0]}
          = irq_priority_in;
        program_counter_d = pc_load_in;
      end
      `CRF_OP_RSP:
      begin
        stack_pointer_d = `CRF_SP_RST;
      end
      `CRF_OP_JUMP:
      begin
        program_counter_d = pc_load_in;
      end
      default:
      begin
        cond_bit = 1'b0;
      end
    endcase
    if (write_res)
    begin
      if (dst_sel_in == `CRF_DST_IDX1)
      begin
        idx1_d = result;
      end
      else if (dst_sel_in == `CRF_DST_IDX2)
      begin
        idx2_d = result;
      end
      else
      begin
        acc_d = result;
      end
    end
    if (upd_nz)
    begin
      condition_flags_d[`CRF_BIT_N] = result[7];
      condition_flags_d[`CRF_BIT_Z] = (result == 8'h00);
    end
    case (br_cond_in)
      `CRF_BR_H: cond_bit = condition_flags_q[`CRF_BIT_H];
      `CRF_BR_N: cond_bit = condition_flags_q[`CRF_BIT_N];
      `CRF_BR_Z: cond_bit = condition_flags_q[`CRF_BIT_Z];
      `CRF_BR_C: cond_bit = condition_flags_q[`CRF_BIT_C];
      `CRF_BR_I1: cond_bit = condition_flags_q[`CRF_BIT_I1];
      `CRF_BR_I0: cond_bit = condition_flags_q[`CRF_BIT_I0];
      default: cond_bit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // State registers.
  // ---------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      acc_q <= 8'h00;
      idx1_q <= 8'h00;
      idx2_q <= 8'h00;
      program_counter_q <= 16'h0000;
      condition_flags_q <= `CRF_FLAGS_RST;
      stack_pointer_q <= `CRF_SP_RST;
      acc_out <= 8'h00;
      idx1_out <= 8'h00;
      idx2_out <= 8'h00;
      program_counter_low_out <= 8'h00;
      program_counter_high_out <= 8'h00;
      condition_flags_out <= `CRF_FLAGS_RST;
      stack_pointer_out <= `CRF_SP_RST;
      branch_taken_out <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      idx1_q <= idx1_d;
      idx2_q <= idx2_d;
      program_counter_q <= program_counter_d;
      condition_flags_q <= condition_flags_d | `CRF_FIXED_ONES;
      stack_pointer_q <= stack_pointer_d;
      acc_out <= acc_d;
      idx1_out <= idx1_d;
      idx2_out <= idx2_d;
      program_counter_low_out <= program_counter_d[7:0];
      program_counter_high_out <= program_counter_d[15:8];
      condition_flags_out <= condition_flags_d | `CRF_FIXED_ONES;
      stack_pointer_out <= stack_pointer_d;
      branch_taken_out <= (cond_bit == br_true_in);
    end
  end

endmodule // crf_core_regs
`default_nettype wire

// file: verilog/crf_consts.vh
// Constants for the core register file and flag unit.
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH
// Condition flag bit positions.
`define CRF_BIT_C 0
`define CRF_BIT_Z 1
`define CRF_BIT_N 2
`define CRF_BIT_I0 3
`define CRF_BIT_H 4
`define CRF_BIT_I1 5
// Reset values, fixed bits and stack pointer mask.
`define CRF_FLAGS_RST 8'hE8
`define CRF_FIXED_ONES 8'hC0
`define CRF_SP_RST 16'h017F
`define CRF_SP_FIXED 16'h0100
`define CRF_SP_LOW_MASK 16'h007F
// Stack bytes used per call and per interrupt entry.
`define CRF_CALL_BYTES 3'h2
`define CRF_IRQ_BYTES 3'h5
// Operation codes on op_in.
`define CRF_OP_NOP 5'h00
`define CRF_OP_ADD 5'h01
`define CRF_OP_ADC 5'h02
`define CRF_OP_SUB 5'h03
`define CRF_OP_SBC 5'h04
`define CRF_OP_AND 5'h05
`define CRF_OP_OR 5'h06
`define CRF_OP_XOR 5'h07
`define CRF_OP_LD 5'h08
`define CRF_OP_SHL 5'h09
`define CRF_OP_SHR 5'h0A
`define CRF_OP_RLC 5'h0B
`define CRF_OP_RRC 5'h0C
`define CRF_OP_MUL 5'h0D
`define CRF_OP_SCF 5'h0E
`define CRF_OP_RCF 5'h0F
`define CRF_OP_RIM 5'h10
`define CRF_OP_SIM 5'h11
`define CRF_OP_BTJ 5'h12
`define CRF_OP_CALL 5'h13
`define CRF_OP_RET 5'h14
`define CRF_OP_IRQ 5'h15
`define CRF_OP_IRQ_RETURN_OP 5'h16
`define CRF_OP_PUSHF 5'h17
`define CRF_OP_POPF 5'h18
`define CRF_OP_RSP 5'h19
`define CRF_OP_HALT 5'h1A
`define CRF_OP_WFI 5'h1B
`define CRF_OP_WRFLAGS 5'h1C
`define CRF_OP_JUMP 5'h1D
// Destination select.
`define CRF_DST_ACC 2'h0
`define CRF_DST_IDX1 2'h1
`define CRF_DST_IDX2 2'h2
// Branch condition codes.
`define CRF_BR_H 3'h0
`define CRF_BR_N 3'h1
`define CRF_BR_Z 3'h2
`define CRF_BR_C 3'h3
`define CRF_BR_I1 3'h4
`define CRF_BR_I0 3'h5
// Priority levels encoded in the two mask bits.
`define CRF_LVL_MAIN 2'h2
`define CRF_LVL_DISABLE 2'h3
`endif

// file: sim/crf_core_regs_properties.sv
// Assertions for the core register and flag unit.
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.vh"
module crf_core_regs_properties
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Requests.
  input wire logic [4:0] op_in,
  input wire logic [1:0] dst_sel_in,
  input wire logic prefix_in,
  input wire logic [7:0] operand_in,
  input wire logic [1:0] irq_priority_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [2:0] br_cond_in,
  input wire logic br_true_in,
  // State.
  input wire logic [7:0] acc_out,
  input wire logic [7:0] idx1_out,
  input wire logic [7:0] idx2_out,
  input wire logic [7:0] condition_flags_out,
  input wire logic [15:0] stack_pointer_out,
  input wire logic branch_taken_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  wire logic [1:0] mask = {condition_flags_out[5], condition_flags_out[3]};
  wire logic test_bit = operand_in[bit_sel_in];
  function automatic logic [15:0] sp_add(input logic [15:0] s, input logic [6:0] d);
    return {9'h002, s[6:0] + d};
  endfunction
  sequence acc_add;
    op_in == `CRF_OP_ADD && dst_sel_in == `CRF_DST_ACC;
  endsequence
  sequence irq_entry;
    op_in == `CRF_OP_IRQ;
  endsequence
  fixed_bits_a:
    assert property (condition_flags_out[7:6] == 2'h3 && stack_pointer_out[15:7] == 9'h002)
    else $error("fixed bits wrong");
  half_carry_a:
    assert property (acc_add |=> condition_flags_out[4] ==
      ($past(acc_out[3:0]) + $past(operand_in[3:0]) > 5'h0F)) else $error("half carry wrong");
  add_sum_a:
    assert property (acc_add |=> {condition_flags_out[0], acc_out} ==
      $past(acc_out) + $past(operand_in)) else $error("sum or carry wrong");
  sign_zero_a:
    assert property (op_in inside {`CRF_OP_LD, `CRF_OP_AND, `CRF_OP_XOR} && dst_sel_in == 2'h0
      |=> condition_flags_out[2] == acc_out[7] && condition_flags_out[1] == (acc_out == 8'h00))
    else $error("sign or zero flag wrong");
  carry_ops_a:
    assert property (op_in == `CRF_OP_SCF || op_in == `CRF_OP_RCF |=>
      condition_flags_out[0] == ($past(op_in) == `CRF_OP_SCF)) else $error("carry op wrong");
  bit_test_a:
    assert property (op_in == `CRF_OP_BTJ |=> condition_flags_out[0] == $past(test_bit))
    else $error("bit test carry wrong");
  mask_ops_a:
    assert property (op_in inside {`CRF_OP_SIM, `CRF_OP_RIM, `CRF_OP_HALT, `CRF_OP_WFI} |=>
      mask == (($past(op_in) == `CRF_OP_SIM) ? 2'h3 : 2'h2)) else $error("mask level wrong");
  irq_entry_a:
    assert property (irq_entry |=> mask == $past(irq_priority_in) && $stable(idx2_out) &&
      stack_pointer_out == sp_add($past(stack_pointer_out), 7'h7B)) else $error("entry wrong");
  call_stack_a:
    assert property (op_in == `CRF_OP_CALL ##1 1'b1 |-> stack_pointer_out ==
      sp_add($past(stack_pointer_out), 7'h7E)) else $error("call stack wrong");
  reset_stack_a:
    assert property (op_in == `CRF_OP_RSP |=> stack_pointer_out == 16'h017F)
    else $error("stack reset wrong");
  multiply_a:
    assert property (op_in == `CRF_OP_MUL && !prefix_in |=>
      {idx1_out, acc_out} == $past(idx1_out) * $past(acc_out)) else $error("product wrong");
  branch_zero_a:
    assert property (br_cond_in == `CRF_BR_Z |=> branch_taken_out ==
      ($past(condition_flags_out[1]) == $past(br_true_in))) else $error("branch wrong");
endmodule // crf_core_regs_properties
bind crf_core_regs crf_core_regs_properties i_props (.clk_sys_in, .rst_n_in, .op_in,
  .dst_sel_in, .prefix_in, .operand_in, .irq_priority_in, .bit_sel_in, .br_cond_in,
  .br_true_in, .acc_out, .idx1_out, .idx2_out, .condition_flags_out, .stack_pointer_out,
  .branch_taken_out);
`default_nettype wire

// file: sim/crf_core_regs_tb_top.sv
// Self-checking bench of the core register and flag unit.
`timescale 1ns/1ps
`default_nettype none
`include "crf_consts.vh"
module crf_core_regs_tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [4:0] op_in = 5'h00;
  logic [1:0] dst_sel_in = 2'h0;
  logic prefix_in = 1'b0;
  logic [7:0] operand_in = 8'h00;
  logic [7:0] wr_flags_in = 8'h00;
  logic [15:0] pc_load_in = 16'h0000;
  logic [1:0] irq_priority_in = 2'h0;
  logic [2:0] bit_sel_in = 3'h0;
  logic [2:0] br_cond_in = 3'h0;
  logic br_true_in = 1'b0;
  wire logic [7:0] acc, idx1, idx2, program_counter_low, program_counter_high, fl;
  wire logic [15:0] sp;
  wire logic br;
  int n_fail = 0;
  int checks_done = 0;
  logic [15:0] rnd = 16'h5262;
  logic [15:0] ab;
  logic [9:0] ex;
  int i;
  always #10 clk_sys_in = ~clk_sys_in;
  crf_core_regs i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .op_in(op_in),
    .dst_sel_in(dst_sel_in), .prefix_in(prefix_in), .operand_in(operand_in),
    .wr_flags_in(wr_flags_in), .pc_load_in(pc_load_in), .irq_priority_in(irq_priority_in),
    .bit_sel_in(bit_sel_in), .br_cond_in(br_cond_in), .br_true_in(br_true_in),
    .acc_out(acc), .idx1_out(idx1), .idx2_out(idx2), .program_counter_low_out(program_counter_low),
    .program_counter_high_out(program_counter_high), .condition_flags_out(fl), .stack_pointer_out(sp),
    .branch_taken_out(br));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Returns half carry, carry and the eight-bit sum.
  function automatic logic [9:0] add_exp(input logic [7:0] a, input logic [7:0] b,
    input logic c);
    return {({1'b0, a[3:0]} + b[3:0] + c) > 5'h0F, {1'b0, a} + b + c};
  endfunction
  function automatic logic [2:0] fpos(input logic [2:0] c);
    case (c)
      3'h0: return 3'h4;
      3'h1: return 3'h2;
      3'h2: return 3'h1;
      3'h3: return 3'h0;
      3'h4: return 3'h5;
      default: return 3'h3;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [4:0] o, input logic [1:0] d, input logic [7:0] a);
    op_in = o;
    dst_sel_in = d;
    operand_in = a;
    @(negedge clk_sys_in);
    op_in = `CRF_OP_NOP;
  endtask
  task automatic test_done;
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    chk({fl, program_counter_high, program_counter_low}, {`CRF_FLAGS_RST, 16'h0000});
    chk(sp, 16'h017F);
    for (i = 0; i < 40; i++)
    begin
      rnd = lfsr(rnd);
      ab = (i < 2) ? 16'h01FF : rnd;
      run(`CRF_OP_LD, `CRF_DST_ACC, ab[7:0]);
      ex = add_exp(ab[7:0], ab[15:8], i[0] & fl[0]);
      run(i[0] ? `CRF_OP_ADC : `CRF_OP_ADD, `CRF_DST_ACC, ab[15:8]);
      chk({acc, fl[4], fl[2:0]}, {ex[7:0], ex[9], ex[7], ex[7:0] == 8'h00, ex[8]});
    end
    run(`CRF_OP_LD, `CRF_DST_ACC, 8'h05);
    run(`CRF_OP_SUB, `CRF_DST_ACC, 8'h06);
    chk({acc, fl[2], fl[0]}, {8'hFF, 2'h3});
    run(`CRF_OP_SCF, `CRF_DST_ACC, 8'h00);
    chk(fl[0], 1'b1);
    run(`CRF_OP_RCF, `CRF_DST_ACC, 8'h00);
    chk(fl[0], 1'b0);
    bit_sel_in = rnd[10:8];
    run(`CRF_OP_BTJ, `CRF_DST_ACC, rnd[7:0]);
    chk(fl[0], rnd[rnd[10:8]]);
    run(`CRF_OP_SHL, `CRF_DST_ACC, 8'h81);
    chk({acc, fl[0]}, {8'h02, 1'b1});
    run(`CRF_OP_SIM, `CRF_DST_ACC, 8'h00);
    chk({fl[5], fl[3]}, 2'h3);
    run(`CRF_OP_WFI, `CRF_DST_ACC, 8'h00);
    chk({fl[5], fl[3]}, 2'h2);
    run(`CRF_OP_LD, `CRF_DST_IDX2, 8'h5A);
    irq_priority_in = 2'h1;
    pc_load_in = 16'hBE3C;
    run(`CRF_OP_IRQ, `CRF_DST_ACC, 8'h00);
    chk({idx2, fl[5], fl[3], 6'h00}, 16'h5A40);
    chk(sp, 16'h017A);
    chk({program_counter_high, program_counter_low}, 16'hBE3C);
    wr_flags_in = 8'h2A;
    run(`CRF_OP_IRQ_RETURN_OP, `CRF_DST_ACC, 8'h00);
    chk({fl, idx2}, 16'hEA5A);
    chk(sp, 16'h017F);
    run(`CRF_OP_CALL, `CRF_DST_ACC, 8'h00);
    chk(sp, 16'h017D);
    run(`CRF_OP_POPF, `CRF_DST_ACC, 8'h00);
    run(`CRF_OP_POPF, `CRF_DST_ACC, 8'h00);
    run(`CRF_OP_POPF, `CRF_DST_ACC, 8'h00);
    chk(sp, 16'h0100);
    run(`CRF_OP_RSP, `CRF_DST_ACC, 8'h00);
    chk(sp, 16'h017F);
    run(`CRF_OP_PUSHF, `CRF_DST_ACC, 8'h00);
    chk(sp, 16'h017E);
    run(`CRF_OP_LD, `CRF_DST_ACC, 8'hC8);
    run(`CRF_OP_LD, `CRF_DST_IDX1, 8'h0F);
    run(`CRF_OP_MUL, `CRF_DST_ACC, 8'h00);
    chk({idx1, acc}, 16'h0BB8);
    prefix_in = 1'b1;
    run(`CRF_OP_MUL, `CRF_DST_ACC, 8'h00);
    chk({idx2, acc}, 16'h40B0);
    for (i = 0; i < 12; i++)
    begin
      rnd = lfsr(rnd);
      wr_flags_in = rnd[7:0];
      run(`CRF_OP_WRFLAGS, `CRF_DST_ACC, 8'h00);
      br_cond_in = i[3:1];
      br_true_in = i[0];
      run(`CRF_OP_NOP, `CRF_DST_ACC, 8'h00);
      chk(br, rnd[fpos(i[3:1])] == i[0]);
    end
    for (i = 0; i < 300; i++)
    begin
      rnd = lfsr(rnd);
      {prefix_in, bit_sel_in, irq_priority_in, br_true_in} = rnd[15:9];
      br_cond_in = rnd[10:8] % 6;
      run(rnd[4:0], rnd[6:5] % 3, rnd[15:8]);
    end
    rst_n_in = 1'b0;
    @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    chk({fl, sp[7:0]}, 16'hE87F);
    chk({acc, program_counter_high}, 16'h0000);
    test_done;
  end
endmodule // crf_core_regs_tb_top
`default_nettype wire
